// >>> verilog/tcb_core.sv
// Serial target front end, save sequencer and sensing filters of the controller.
// Assumes SCL/SDA arrive asynchronously; sensing strobes come from the clk domain.
`timescale 1ns/1ps

// Functional notes
// - Critical register accesses acknowledged within 140 us.
// - Save command acknowledged within 100 us.
// - Busy after save ack; all else refused.
// - Averaging filter over 2/4/8/16 samples.
// - Drop sample if bus traffic during scan.
// - Save fails at 512 Hz or 64 Hz.
// - Finger at power-up with averaging: stuck active.
// - During boot any byte may match address.
module tcb_core #(
  parameter int unsigned        ACK_LAT_CYC  = 2500,
  parameter int unsigned        SAVE_ACK_CYC = 2500,
  parameter int unsigned        SAVE_CYC     = 250000,
  parameter int unsigned        BOOT_CYC     = 25000,
  parameter logic [15:0]        TOUCH_TH     = 16'h0100
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Serial bus pins
  input  wire logic             scl_in,
  output logic                  scl_out,
  output logic                  scl_oe,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  // Configuration
  input  wire logic [6:0]       dev_addr,
  input  wire logic [1:0]       sleep_sel,
  input  wire logic             avg_en,
  input  wire logic [1:0]       avg_sel,
  input  wire logic             drop_en,
  // Sensing
  input  wire logic             scan_start,
  input  wire logic             raw_valid,
  input  wire logic [15:0]      raw_count,
  input  wire logic             finger_pwrup,
  // Status
  output logic                  filt_valid,
  output logic [15:0]           filt_count,
  output logic                  sample_dropped,
  output logic                  button_active,
  output logic                  baseline_stuck,
  output logic                  boot_done,
  output logic                  save_busy,
  output logic                  save_done,
  output logic                  save_ok
);

  localparam int CW = tcb_pkg::CNT_W;
  localparam logic [CW-1:0] ACK_LAT_M1  = CW'(ACK_LAT_CYC - 1);
  localparam logic [CW-1:0] SAVE_ACK_M1 = CW'(SAVE_ACK_CYC - 1);
  localparam logic [CW-1:0] SAVE_M1     = CW'(SAVE_CYC - 1);
  localparam logic [CW-1:0] BOOT_INIT   = CW'(BOOT_CYC);

  if (ACK_LAT_CYC < 1 || ACK_LAT_CYC > tcb_pkg::ACK_MAX_CYC ||
      SAVE_ACK_CYC < 1 || SAVE_ACK_CYC > tcb_pkg::SAVE_ACK_MAX_CYC ||
      SAVE_CYC < 1 || SAVE_CYC >= (1 << CW) || BOOT_CYC >= (1 << CW)) begin : g_bad_param
    $error("tcb_core: timing parameter out of range");
  end

  // ************************************************************
  // Pin synchronisers and bus events
  // ************************************************************
  logic scl_m_reg, scl_s_reg, scl_d_reg, sda_m_reg, sda_s_reg, sda_d_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
      {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
    end else begin
      {scl_m_reg, scl_s_reg, scl_d_reg} <= {scl_in, scl_m_reg, scl_s_reg};
      {sda_m_reg, sda_s_reg, sda_d_reg} <= {sda_in, sda_m_reg, sda_s_reg};
    end
  end
  wire scl_rise = scl_s_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s_reg & scl_d_reg;
  wire start_ev = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
  wire stop_ev  = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;

  // ************************************************************
  // Target state machine
  // ************************************************************
  tcb_pkg::tcb_state_t st_reg, st_next;
  logic [3:0]    bit_reg, bit_next;
  logic [7:0]    sh_reg, sh_next;
  logic          first_reg, first_next, rw_reg, rw_next, cmd_reg, cmd_next;
  logic [CW-1:0] lat_reg, lat_next, age_reg, age_next;
  logic          scl_oe_next, sda_oe_next, save_req;
  logic          booting_reg, save_busy_reg, save_ok_reg, button_active_reg;
  logic [7:0]    status;

  always_comb begin
    status = 8'h00;
    status[tcb_pkg::STAT_ACTIVE_BIT] = button_active_reg;
    status[tcb_pkg::STAT_SAVEOK_BIT] = save_ok_reg;
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    first_next = first_reg;
    rw_next = rw_reg;
    cmd_next = cmd_reg;
    lat_next = lat_reg;
    scl_oe_next = 1'b0;
    sda_oe_next = 1'b0;
    save_req = 1'b0;
    case (st_reg)
      tcb_pkg::ST_IDLE: ;
      tcb_pkg::ST_RX: begin
        if (scl_rise) begin
          sh_next = {sh_reg[6:0], sda_s_reg};
          bit_next = bit_reg + 4'h1;
        end else if (scl_fall && bit_reg == tcb_pkg::BIT_LAST) begin
          if (save_busy_reg) begin
            st_next = tcb_pkg::ST_IDLE;
          end else if (first_reg) begin
            // Boot-time misreading: every address byte is taken as ours
            if (sh_reg[7:1] == dev_addr || booting_reg) begin
              rw_next = sh_reg[0];
              first_next = 1'b0;
              cmd_next = 1'b1;
              lat_next = ACK_LAT_M1;
              scl_oe_next = 1'b1;
              st_next = tcb_pkg::ST_STRETCH;
            end else begin
              st_next = tcb_pkg::ST_IDLE;
            end
          end else begin
            save_req = cmd_reg && sh_reg == tcb_pkg::CMD_SAVE;
            lat_next = save_req ? SAVE_ACK_M1 : ACK_LAT_M1;
            cmd_next = 1'b0;
            scl_oe_next = 1'b1;
            st_next = tcb_pkg::ST_STRETCH;
          end
        end
      end
      tcb_pkg::ST_STRETCH: begin
        // Ack level set while SCL is still held low
        sda_oe_next = 1'b1;
        scl_oe_next = (lat_reg != '0);
        if (lat_reg == '0) begin
          st_next = tcb_pkg::ST_ACK;
        end else begin
          lat_next = lat_reg - 1'b1;
        end
      end
      tcb_pkg::ST_ACK: begin
        sda_oe_next = 1'b1;
        if (scl_fall) begin
          bit_next = 4'h0;
          if (rw_reg) begin
            sh_next = status;
            sda_oe_next = ~status[7];
            st_next = tcb_pkg::ST_TX;
          end else begin
            sda_oe_next = 1'b0;
            st_next = tcb_pkg::ST_RX;
          end
        end
      end
      tcb_pkg::ST_TX: begin
        sda_oe_next = ~sh_reg[7];
        if (scl_fall) begin
          sh_next = {sh_reg[6:0], 1'b0};
          bit_next = bit_reg + 4'h1;
          sda_oe_next = ~sh_reg[6];
          // One status byte per read; master ack is ignored
          if (bit_reg == tcb_pkg::TX_LAST) begin
            sda_oe_next = 1'b0;
            st_next = tcb_pkg::ST_IDLE;
          end
        end
      end
      default: st_next = tcb_pkg::ST_IDLE;
    endcase
    if (stop_ev || start_ev) begin
      st_next = start_ev ? tcb_pkg::ST_RX : tcb_pkg::ST_IDLE;
      bit_next = 4'h0;
      first_next = 1'b1;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
      save_req = 1'b0;
    end
    age_next = (st_next == tcb_pkg::ST_STRETCH) ? age_reg + 1'b1 : '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= tcb_pkg::ST_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      first_reg <= 1'b1;
      rw_reg <= 1'b0;
      cmd_reg <= 1'b0;
      lat_reg <= '0;
      age_reg <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      first_reg <= first_next;
      rw_reg <= rw_next;
      cmd_reg <= cmd_next;
      lat_reg <= lat_next;
      age_reg <= age_next;
      scl_oe <= scl_oe_next;
      sda_oe <= sda_oe_next;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // ************************************************************
  // Boot window and save sequencer
  // ************************************************************
  logic [CW-1:0] boot_cnt_reg, boot_cnt_next, save_cnt_reg, save_cnt_next;
  logic          booting_next, save_busy_next, save_done_next, save_ok_next;
  wire           save_fin = save_busy_reg && save_cnt_reg == '0;
  wire           slp_bad  = sleep_sel == tcb_pkg::SLP_512HZ || sleep_sel == tcb_pkg::SLP_64HZ;

  always_comb begin
    boot_cnt_next = (boot_cnt_reg != '0) ? boot_cnt_reg - 1'b1 : boot_cnt_reg;
    booting_next = boot_cnt_next != '0;
    save_busy_next = save_busy_reg;
    save_cnt_next = save_cnt_reg;
    save_done_next = 1'b0;
    save_ok_next = save_ok_reg;
    if (save_req) begin
      save_busy_next = 1'b1;
      save_cnt_next = SAVE_M1;
    end else if (save_fin) begin
      save_busy_next = 1'b0;
      save_done_next = 1'b1;
      save_ok_next = ~slp_bad;
    end else if (save_busy_reg) begin
      save_cnt_next = save_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_cnt_reg <= BOOT_INIT;
      booting_reg <= 1'b1;
      boot_done <= 1'b0;
      save_busy_reg <= 1'b0;
      save_cnt_reg <= '0;
      save_done <= 1'b0;
      save_ok_reg <= 1'b0;
    end else begin
      boot_cnt_reg <= boot_cnt_next;
      booting_reg <= booting_next;
      boot_done <= ~booting_next;
      save_busy_reg <= save_busy_next;
      save_cnt_reg <= save_cnt_next;
      save_done <= save_done_next;
      save_ok_reg <= save_ok_next;
    end
  end
  assign save_busy = save_busy_reg;
  assign save_ok = save_ok_reg;

  // ************************************************************
  // Drop and averaging filters, baseline
  // ************************************************************
  logic                      bus_act_reg, bus_act_next, drop_next, fv_next;
  logic [3:0]                avg_cnt_reg, avg_cnt_next, avg_last;
  logic [tcb_pkg::ACC_W-1:0] acc_reg, acc_next, sum;
  logic [15:0]               filt_next, base_reg, base_next;
  logic                      first_smp_reg, first_smp_next, stuck_next, act_next;
  logic [16:0]               base_th;
  wire                       smp_keep = raw_valid && !(drop_en && bus_act_reg);

  always_comb begin
    // Traffic in the same cycle as a scan start still counts
    bus_act_next = start_ev | (bus_act_reg & ~scan_start);
    avg_last = 4'((5'h02 << avg_sel) - 5'h01);
    sum = acc_reg + tcb_pkg::ACC_W'(raw_count);
    acc_next = acc_reg;
    avg_cnt_next = avg_cnt_reg;
    filt_next = filt_count;
    fv_next = 1'b0;
    drop_next = raw_valid && drop_en && bus_act_reg;
    if (!avg_en) begin
      acc_next = '0;
      avg_cnt_next = 4'h0;
    end
    if (smp_keep) begin
      if (avg_en && avg_cnt_reg == avg_last) begin
        filt_next = 16'(sum >> ({1'b0, avg_sel} + 3'h1));
        fv_next = 1'b1;
        acc_next = '0;
        avg_cnt_next = 4'h0;
      end else if (avg_en) begin
        acc_next = sum;
        avg_cnt_next = avg_cnt_reg + 4'h1;
      end else begin
        filt_next = raw_count;
        fv_next = 1'b1;
      end
    end
    base_th = {1'b0, base_reg} + {1'b0, TOUCH_TH};
    base_next = base_reg;
    first_smp_next = first_smp_reg;
    stuck_next = baseline_stuck;
    act_next = button_active_reg;
    if (filt_valid) begin
      if (first_smp_reg) begin
        base_next = filt_count;
        first_smp_next = 1'b0;
        stuck_next = avg_en & finger_pwrup;
        act_next = avg_en & finger_pwrup;
      end else if (baseline_stuck) begin
        act_next = 1'b1;
      end else begin
        act_next = {1'b0, filt_count} > base_th;
        if ({1'b0, filt_count} <= base_th) begin
          base_next = filt_count;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_act_reg <= 1'b0;
      avg_cnt_reg <= 4'h0;
      acc_reg <= '0;
      filt_count <= 16'h0000;
      filt_valid <= 1'b0;
      sample_dropped <= 1'b0;
      base_reg <= 16'h0000;
      first_smp_reg <= 1'b1;
      baseline_stuck <= 1'b0;
      button_active_reg <= 1'b0;
    end else begin
      bus_act_reg <= bus_act_next;
      avg_cnt_reg <= avg_cnt_next;
      acc_reg <= acc_next;
      filt_count <= filt_next;
      filt_valid <= fv_next;
      sample_dropped <= drop_next;
      base_reg <= base_next;
      first_smp_reg <= first_smp_next;
      baseline_stuck <= stuck_next;
      button_active_reg <= act_next;
    end
  end
  assign button_active = button_active_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire addr_done = st_reg == tcb_pkg::ST_RX && scl_fall && bit_reg == tcb_pkg::BIT_LAST;
  wire avg_hit   = smp_keep && avg_en && avg_cnt_reg == avg_last;

  property p_ack_lat;
    st_reg == tcb_pkg::ST_STRETCH && !save_busy_reg |-> age_reg <= CW'(tcb_pkg::ACK_MAX_CYC);
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack latency over limit");
  property p_save_ack;
    st_reg == tcb_pkg::ST_STRETCH && save_busy_reg |->
      age_reg <= CW'(tcb_pkg::SAVE_ACK_MAX_CYC);
  endproperty
  a_save_ack: assert property (p_save_ack) else $error("save ack too late");
  property p_busy_refuse;
    addr_done && save_busy_reg && !start_ev && !stop_ev |=>
      st_reg == tcb_pkg::ST_IDLE ##1 !sda_oe && !scl_oe;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("access taken while busy");
  property p_avg;
    raw_valid |=> filt_valid == ($past(avg_hit) || $past(smp_keep && !avg_en));
  endproperty
  a_avg: assert property (p_avg) else $error("average output count wrong");
  property p_drop;
    raw_valid && drop_en && bus_act_reg |=> sample_dropped && !filt_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("sample not dropped");
  property p_save_fail;
    save_fin && slp_bad |=> save_done && !save_ok;
  endproperty
  a_save_fail: assert property (p_save_fail) else $error("save succeeded at fast sleep");
  property p_stuck;
    baseline_stuck && filt_valid |=> button_active && $stable(base_reg);
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck baseline moved");
  property p_boot_match;
    addr_done && first_reg && booting_reg && !save_busy_reg && !start_ev && !stop_ev |=>
      st_reg == tcb_pkg::ST_STRETCH && scl_oe;
  endproperty
  a_boot_match: assert property (p_boot_match) else $error("boot byte not taken");

  c_save_done: cover property (save_done && save_ok);
  c_dropped:   cover property (sample_dropped);
  c_read:      cover property (st_reg == tcb_pkg::ST_TX && scl_fall);
  c_avg16:     cover property (avg_hit && avg_sel == 2'h3);

endmodule

// >>> verilog/tcb_pkg.sv
// Constants, encodings and state codes of the touch button controller core.
// Assumes a single 250 MHz core clock; the ack limit counts are derived here.
package tcb_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int ACK_MAX_US        = 140;
  localparam int SAVE_ACK_MAX_US   = 100;
  // Longest times: round down to whole cycles
  localparam int ACK_MAX_CYC       = (ACK_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int SAVE_ACK_MAX_CYC  = (SAVE_ACK_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int CNT_W             = 20;

  // ************************************************************
  // Widths and codes
  // ************************************************************
  localparam int ADDR_W            = 7;
  localparam int DATA_W            = 8;
  localparam int RAW_W             = 16;
  localparam int ACC_W             = 20;
  localparam logic [3:0] BIT_LAST  = 4'h8;
  localparam logic [3:0] TX_LAST   = 4'h7;
  localparam logic [7:0] CMD_SAVE  = 8'ha0;
  localparam int STAT_ACTIVE_BIT   = 0;
  localparam int STAT_SAVEOK_BIT   = 1;

  // Sleep interval select
  localparam logic [1:0] SLP_512HZ = 2'h0;
  localparam logic [1:0] SLP_64HZ  = 2'h1;
  localparam logic [1:0] SLP_8HZ   = 2'h2;
  localparam logic [1:0] SLP_1HZ   = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_RX      = 5'h02,
    ST_STRETCH = 5'h04,
    ST_ACK     = 5'h08,
    ST_TX      = 5'h10
  } tcb_state_t;

endpackage

// >>> test/tcb_host.sv
// Behavioural serial bus host that configures and polls the button controller.
// Assumes the bench resolves open-drain SCL/SDA with pull-ups and feeds levels back.
`timescale 1ns/1ps
module tcb_host #(
  parameter int HALF_CYC  = 20,
  parameter int WAIT_MAX  = 40000,
  parameter int BOOT_WAIT = 2100
) (
  // Clock and resolved bus levels
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  // Pull-down enables
  output logic      scl_low,
  output logic      sda_low
);
  // ************************************************************
  // Bus primitives
  // ************************************************************
  // Lines released at start, so the bus idles high via pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic half();
    repeat (HALF_CYC) @(negedge clk);
  endtask

  // Bounded wait so a stuck stretch cannot hang the host
  task automatic rise(output int lat);
    lat = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && lat < WAIT_MAX) begin
      @(negedge clk);
      lat++;
    end
  endtask

  task automatic boot_wait();
    repeat (BOOT_WAIT) @(negedge clk);
  endtask

  task automatic start();
    int l;
    sda_low = 1'b0;
    half();
    rise(l);
    half();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
  endtask

  task automatic stop();
    int l;
    sda_low = 1'b1;
    half();
    rise(l);
    half();
    sda_low = 1'b0;
    half();
  endtask

  // Latency counts from the eighth SCL fall to the freed ack clock
  task automatic send_byte(input logic [7:0] b, output logic ack, output int lat);
    int l;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      half();
      rise(l);
      half();
      scl_low = 1'b1;
    end
    sda_low = 1'b0;
    half();
    rise(l);
    lat = HALF_CYC + l;
    ack = ~sda;
    half();
    scl_low = 1'b1;
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    int l;
    sda_low = 1'b0;
    for (int i = 0; i < 8; i++) begin
      half();
      rise(l);
      d = {d[6:0], sda};
      half();
      scl_low = 1'b1;
    end
    sda_low = ~nack;
    half();
    rise(l);
    half();
    // Ack level held until the next byte or stop takes SDA over
    scl_low = 1'b1;
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the button controller core and its bus host model.
// Assumes tcb_core and tcb_host are compiled; shortened counts set below.
`timescale 1ns/1ps
module tb;
  localparam int ACK_LAT  = 60;
  localparam int SAVE_ACK = 100;
  localparam int SAVE_LEN = 2000;
  localparam int BOOT_LEN = 2000;
  localparam logic [6:0] ADDR = 7'h2a;

  logic        clk, srst, scan_start, raw_valid, finger_pwrup, avg_en, drop_en;
  logic [1:0]  sleep_sel, avg_sel;
  logic [15:0] raw_count, filt_count;
  logic        scl_out, scl_oe, sda_out, sda_oe, h_scl_low, h_sda_low, scl_w, sda_w;
  logic        filt_valid, sample_dropped, button_active, baseline_stuck;
  logic        boot_done, save_busy, save_done, save_ok;
  int          failures, tests_run, cyc, rel_cnt;

  // Open-drain resolution with pull-ups
  assign scl_w = !(h_scl_low || (scl_oe && !scl_out));
  assign sda_w = !(h_sda_low || (sda_oe && !sda_out));

  tcb_core #(.ACK_LAT_CYC(ACK_LAT), .SAVE_ACK_CYC(SAVE_ACK), .SAVE_CYC(SAVE_LEN),
    .BOOT_CYC(BOOT_LEN), .TOUCH_TH(16'h0100)) uut (
    .clk(clk), .srst(srst), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr(ADDR),
    .sleep_sel(sleep_sel), .avg_en(avg_en), .avg_sel(avg_sel), .drop_en(drop_en),
    .scan_start(scan_start), .raw_valid(raw_valid), .raw_count(raw_count),
    .finger_pwrup(finger_pwrup), .filt_valid(filt_valid), .filt_count(filt_count),
    .sample_dropped(sample_dropped), .button_active(button_active),
    .baseline_stuck(baseline_stuck), .boot_done(boot_done), .save_busy(save_busy),
    .save_done(save_done), .save_ok(save_ok));

  tcb_host host (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(h_scl_low),
    .sda_low(h_sda_low));

  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    rel_cnt <= srst ? 0 : rel_cnt + 1;
    if (cyc > 60000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_bit(string name, logic exp, logic got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_val(string name, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(string name, int lo, int hi, int got);
    tests_run++;
    if (got < lo || got > hi) begin
      failures++;
      $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (8) @(negedge clk);
    srst = 1'b0;
  endtask

  // Pulses one raw sample and watches three cycles for the answer
  task automatic raw(logic [15:0] v, output logic fv, output logic dv);
    fv = 1'b0;
    dv = 1'b0;
    raw_valid = 1'b1;
    raw_count = v;
    @(negedge clk);
    raw_valid = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (k > 0) @(negedge clk);
      if (filt_valid === 1'b1) fv = 1'b1;
      if (sample_dropped === 1'b1) dv = 1'b1;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_finger();
    logic fv, dv;
    avg_en = 1'b1;
    finger_pwrup = 1'b1;
    raw(16'h0400, fv, dv);
    raw(16'h0400, fv, dv);
    repeat (4) @(negedge clk);
    chk_bit("baseline_stuck", 1'b1, baseline_stuck);
    chk_bit("button_active", 1'b1, button_active);
    $display("finger test done, failures %0d", failures);
  endtask

  task automatic t_boot();
    logic ack;
    int lat;
    host.start();
    host.send_byte(8'haa, ack, lat);
    chk_bit("boot ack", 1'b1, ack);
    host.stop();
    while (rel_cnt < BOOT_LEN - 2) @(negedge clk);
    chk_bit("boot_done early", 1'b0, boot_done);
    while (rel_cnt < BOOT_LEN + 2) @(negedge clk);
    chk_bit("boot_done", 1'b1, boot_done);
    host.start();
    host.send_byte(8'haa, ack, lat);
    chk_bit("foreign ack", 1'b0, ack);
    host.stop();
    $display("boot test done, failures %0d", failures);
  endtask

  task automatic t_save(logic [1:0] sel, logic exp_ok);
    logic ack;
    int lat, k;
    sleep_sel = sel;
    host.start();
    host.send_byte({ADDR, 1'b0}, ack, lat);
    chk_bit("addr ack", 1'b1, ack);
    host.send_byte(8'ha0, ack, lat);
    chk_bit("save ack", 1'b1, ack);
    chk_rng("save ack latency", SAVE_ACK, SAVE_ACK + 8, lat);
    chk_bit("save_busy", 1'b1, save_busy);
    host.stop();
    host.start();
    host.send_byte({ADDR, 1'b0}, ack, lat);
    chk_bit("busy refusal", 1'b0, ack);
    host.stop();
    k = 0;
    while (save_done !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    chk_bit("save_done", 1'b1, save_done);
    repeat (2) @(negedge clk);
    chk_bit("save_ok", exp_ok, save_ok);
    chk_bit("save_busy end", 1'b0, save_busy);
    $display("save test done, failures %0d", failures);
  endtask

  task automatic t_read();
    logic ack;
    logic [7:0] rd;
    int lat;
    host.start();
    host.send_byte({ADDR, 1'b0}, ack, lat);
    host.send_byte(8'h55, ack, lat);
    chk_bit("plain byte ack", 1'b1, ack);
    chk_rng("data ack latency", ACK_LAT, ACK_LAT + 8, lat);
    chk_bit("no save", 1'b0, save_busy);
    host.stop();
    host.start();
    host.send_byte({ADDR, 1'b1}, ack, lat);
    chk_bit("read ack", 1'b1, ack);
    chk_rng("ack latency", ACK_LAT, ACK_LAT + 8, lat);
    host.recv_byte(1'b1, rd);
    host.stop();
    chk_val("status", 16'h0002, {8'h00, rd});
    $display("read test done, failures %0d", failures);
  endtask

  task automatic t_avg();
    logic fv, dv;
    logic [15:0] v;
    logic [19:0] sum;
    avg_en = 1'b1;
    for (int s = 0; s < 4; s++) begin
      avg_sel = s[1:0];
      sum = 20'h0;
      for (int i = 0; i < (2 << s); i++) begin
        v = 16'h1000 + 16'(i * 3);
        sum = sum + 20'(v);
        raw(v, fv, dv);
        chk_bit("filt_valid", i == (2 << s) - 1, fv);
      end
      chk_val("filt_count", 16'(sum >> (s + 1)), filt_count);
    end
    $display("average test done, failures %0d", failures);
  endtask

  task automatic t_drop();
    logic fv, dv;
    avg_en = 1'b0;
    drop_en = 1'b1;
    for (int b = 1; b >= 0; b--) begin
      scan_start = 1'b1;
      @(negedge clk);
      scan_start = 1'b0;
      if (b == 1) begin
        host.start();
        host.stop();
      end
      raw(16'h1000, fv, dv);
      chk_bit("sample_dropped", b[0], dv);
      chk_bit("kept sample", !b[0], fv);
    end
    $display("drop test done, failures %0d", failures);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {srst, scan_start, raw_valid, finger_pwrup, avg_en, drop_en} = 6'h20;
    sleep_sel = 2'h2;
    avg_sel = 2'h0;
    raw_count = 16'h0000;
    failures = 0;
    tests_run = 0;
    cyc = 0;
    rel_cnt = 0;
    @(negedge clk);
    do_reset();
    t_finger();
    finger_pwrup = 1'b0;
    avg_en = 1'b0;
    do_reset();
    t_boot();
    for (int s = 0; s < 4; s++) t_save(s[1:0], s >= 2);
    sleep_sel = 2'h0;
    @(negedge clk);
    chk_bit("save_ok kept", 1'b1, save_ok);
    t_read();
    t_avg();
    t_drop();
    stop_test();
  end
endmodule
